// [design/serial_port.sv]
// One serial port: FIFOs, baud timing, line modes and RS-485 control
`timescale 1ns/10ps
`include "uart_defs.svh"
module serial_port #(
  parameter  int TX_DEPTH = `DEF_TX_DEPTH,
  parameter  int RX_DEPTH = `DEF_RX_DEPTH,
  localparam int TW       = $clog2(TX_DEPTH + 1),
  localparam int RW       = $clog2(RX_DEPTH + 1)
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // Configuration
  input  wire logic               cfg_write,
  input  wire logic               cfg_defaults,
  input  wire uart_pkg::mode_type cfg_mode,
  input  wire logic               cfg_carrier_sense_deferral,
  input  wire logic               cfg_auto_driver_direction,
  input  wire logic [RW-1:0]      cfg_rx_trigger,
  input  wire logic [TW-1:0]      cfg_tx_trigger,
  input  wire logic [7:0]         cfg_pre_divisor,
  input  wire logic [15:0]        cfg_baud_divisor,
  input  wire logic               manual_drive,
  // Host transmit stream
  input  wire logic [7:0]         tx_data,
  input  wire logic               tx_valid,
  output logic                    tx_ready,
  // Host receive stream
  output logic [7:0]              rx_data,
  output logic                    rx_valid,
  input  wire logic               rx_ready,
  // Interrupt
  input  wire logic               shared_irq_in,
  output logic                    irq,
  // Line
  input  wire logic               rxd,
  output logic                    txd,
  output logic                    driver_enable,
  output logic                    rs232_select,
  // Status
  output logic                    half_duplex,
  output logic                    bus_idle,
  output logic                    tx_active
);

  localparam logic [7:0] IDLE_TICKS = 8'(`IDLE_TICKS);
  localparam logic [3:0] LAST_BIT   = 4'(`CHAR_BITS - 1);
  localparam logic [3:0] STOP_BIT   = 4'(`DATA_BITS);

  typedef struct packed {
    uart_pkg::mode_type     mode;
    logic                   deferral;
    logic                   auto_dir;
    logic [RW-1:0]          rx_trig;
    logic [TW-1:0]          tx_trig;
    logic [7:0]             pre_div;
    logic [15:0]            baud_div;
    logic [7:0]             pre_cnt;
    logic [15:0]            baud_cnt;
    logic                   tick;
    uart_pkg::tx_state_type tx_state;
    logic [3:0]             tx_phase;
    logic [3:0]             tx_bits;
    logic [9:0]             tx_shift;
    logic                   echo_ok;
    logic                   half_seen;
    logic                   half;
    logic                   txd;
    logic                   drive;
    logic                   sel232;
    uart_pkg::rx_state_type rx_state;
    logic [3:0]             rx_phase;
    logic [3:0]             rx_bits;
    logic [7:0]             rx_shift;
    logic                   rx_push;
    logic [7:0]             idle_cnt;
    logic                   bus_idle;
    logic                   irq;
  } state_type;

  localparam state_type RESET_STATE = '{
    mode:     uart_pkg::MODE_RS232,
    deferral: 1'b1,
    auto_dir: 1'b1,
    rx_trig:  RW'(`DEF_RX_TRIGGER),
    tx_trig:  TW'(`DEF_TX_TRIGGER),
    pre_div:  `DEF_PRE_DIV,
    baud_div: `DEF_BAUD_DIV,
    tx_state: uart_pkg::TX_IDLE,
    rx_state: uart_pkg::RX_IDLE,
    txd:      1'b1,
    drive:    1'b1,
    sel232:   1'b1,
    default:  '0
  };

  state_type     st;
  state_type     next_st;
  logic          tx_take;
  logic          defer_active;
  logic          rx_gate;
  logic          rx_hit;
  logic          tx_hit;
  logic [TW-1:0] tx_cnt;
  logic [RW-1:0] rx_cnt;

  stream_if #(.WIDTH(8)) tx_in ();
  stream_if #(.WIDTH(8)) tx_out ();
  stream_if #(.WIDTH(8)) rx_in ();
  stream_if #(.WIDTH(8)) rx_out ();

  // ==========================================================
  // FIFOs
  stream_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) tx_fifo (
    .clock (clock),
    .rst   (rst),
    .fill  (tx_in.sink),
    .drain (tx_out.source),
    .count (tx_cnt)
  );

  stream_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) rx_fifo (
    .clock (clock),
    .rst   (rst),
    .fill  (rx_in.sink),
    .drain (rx_out.source),
    .count (rx_cnt)
  );

  assign tx_in.data   = tx_data;
  assign tx_in.valid  = tx_valid;
  assign tx_ready     = tx_in.ready;
  assign tx_out.ready = tx_take;
  // A byte finished while the FIFO is full is lost (overrun)
  assign rx_in.data   = st.rx_shift;
  assign rx_in.valid  = st.rx_push;
  assign rx_out.ready = rx_ready;
  assign rx_data      = rx_out.data;
  assign rx_valid     = rx_out.valid;

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    tx_take = 1'b0;

    // Pre-divisor first, then the baud divisor; tick is 16x bit rate
    next_st.tick = 1'b0;
    if (st.pre_cnt >= st.pre_div) begin
      next_st.pre_cnt = '0;
      if (st.baud_cnt >= st.baud_div) begin
        next_st.baud_cnt = '0;
        next_st.tick     = 1'b1;
      end else begin
        next_st.baud_cnt = st.baud_cnt + 16'h0001;
      end
    end else begin
      next_st.pre_cnt = st.pre_cnt + 8'h01;
    end

    if (cfg_defaults) begin
      next_st.mode      = RESET_STATE.mode;
      next_st.deferral  = RESET_STATE.deferral;
      next_st.auto_dir  = RESET_STATE.auto_dir;
      next_st.rx_trig   = RESET_STATE.rx_trig;
      next_st.tx_trig   = RESET_STATE.tx_trig;
      next_st.pre_div   = RESET_STATE.pre_div;
      next_st.baud_div  = RESET_STATE.baud_div;
      next_st.half_seen = 1'b0;
    end else if (cfg_write) begin
      next_st.mode      = cfg_mode;
      next_st.deferral  = cfg_carrier_sense_deferral;
      next_st.auto_dir  = cfg_auto_driver_direction;
      next_st.rx_trig   = cfg_rx_trigger;
      next_st.tx_trig   = cfg_tx_trigger;
      next_st.pre_div   = cfg_pre_divisor;
      next_st.baud_div  = cfg_baud_divisor;
      next_st.half_seen = 1'b0;
    end

    // Forced RS-422 is never half duplex, so deferral cannot act there
    defer_active = st.deferral && st.half &&
                   st.mode != uart_pkg::MODE_RS422;

    // Line high for a whole character means nobody is talking
    if (!rxd) begin
      next_st.idle_cnt = '0;
    end else if (st.tick && st.idle_cnt != IDLE_TICKS) begin
      next_st.idle_cnt = st.idle_cnt + 8'h01;
    end
    next_st.bus_idle = next_st.idle_cnt == IDLE_TICKS;

    // ==========================================================
    // Transmitter
    case (st.tx_state)
      uart_pkg::TX_IDLE: begin
        if (tx_out.valid) begin
          tx_take          = 1'b1;
          next_st.tx_shift = {1'b1, tx_out.data, 1'b0};
          next_st.tx_state = uart_pkg::TX_DEFER;
        end
      end
      uart_pkg::TX_DEFER: begin
        if (st.tick && (!defer_active || st.bus_idle)) begin
          next_st.tx_state = uart_pkg::TX_SHIFT;
          next_st.tx_phase = '0;
          next_st.tx_bits  = '0;
          next_st.txd      = st.tx_shift[0];
          next_st.echo_ok  = 1'b1;
        end
      end
      uart_pkg::TX_SHIFT: begin
        if (st.tick) begin
          next_st.tx_phase = st.tx_phase + 4'h1;
          // A pair looped back to our receiver echoes every bit
          if (st.tx_phase == `MID_PHASE && rxd != st.txd) begin
            next_st.echo_ok = 1'b0;
          end
          if (st.tx_phase == `LAST_PHASE) begin
            if (st.tx_bits == LAST_BIT) begin
              if (st.mode == uart_pkg::MODE_AUTO) begin
                next_st.half_seen = st.echo_ok;
              end
              // Queued data follows without giving up the bus
              if (tx_out.valid) begin
                tx_take          = 1'b1;
                next_st.tx_shift = {1'b1, tx_out.data, 1'b0};
                next_st.tx_bits  = '0;
                next_st.txd      = 1'b0;
                next_st.echo_ok  = 1'b1;
              end else begin
                next_st.tx_state = uart_pkg::TX_IDLE;
                next_st.txd      = 1'b1;
              end
            end else begin
              next_st.tx_bits  = st.tx_bits + 4'h1;
              next_st.tx_shift = {1'b1, st.tx_shift[9:1]};
              next_st.txd      = st.tx_shift[1];
            end
          end
        end
      end
      default: begin
        next_st.tx_state = uart_pkg::TX_IDLE;
      end
    endcase

    next_st.half = next_st.mode == uart_pkg::MODE_RS485 ||
                   (next_st.mode == uart_pkg::MODE_AUTO &&
                    next_st.half_seen);
    next_st.sel232 = next_st.mode == uart_pkg::MODE_RS232;
    // Full duplex drives its own pair all the time
    if (!next_st.half) begin
      next_st.drive = 1'b1;
    end else if (next_st.auto_dir) begin
      next_st.drive = next_st.tx_state == uart_pkg::TX_SHIFT;
    end else begin
      next_st.drive = manual_drive;
    end

    // ==========================================================
    // Receiver, deaf to its own echo on a shared pair
    rx_gate         = st.half && st.drive;
    next_st.rx_push = 1'b0;
    case (st.rx_state)
      uart_pkg::RX_IDLE: begin
        if (st.tick && !rxd && !rx_gate) begin
          next_st.rx_state = uart_pkg::RX_START;
          next_st.rx_phase = '0;
        end
      end
      uart_pkg::RX_START: begin
        if (st.tick) begin
          next_st.rx_phase = st.rx_phase + 4'h1;
          if (st.rx_phase == `MID_PHASE) begin
            next_st.rx_state = rxd ? uart_pkg::RX_IDLE
                               : uart_pkg::RX_DATA;
            next_st.rx_phase = '0;
            next_st.rx_bits  = '0;
          end
        end
      end
      uart_pkg::RX_DATA: begin
        if (st.tick) begin
          next_st.rx_phase = st.rx_phase + 4'h1;
          if (st.rx_phase == `LAST_PHASE) begin
            next_st.rx_bits = st.rx_bits + 4'h1;
            if (st.rx_bits == STOP_BIT) begin
              next_st.rx_state = uart_pkg::RX_IDLE;
              next_st.rx_push  = rxd;
            end else begin
              next_st.rx_shift = {rxd, st.rx_shift[7:1]};
            end
          end
        end
      end
      default: begin
        next_st.rx_state = uart_pkg::RX_IDLE;
      end
    endcase

    // ==========================================================
    // Interrupt
    rx_hit = rx_cnt != '0 && rx_cnt >= st.rx_trig;
    if (st.tx_trig == '0) begin
      tx_hit = tx_cnt == '0 &&
               st.tx_state == uart_pkg::TX_IDLE;
    end else begin
      tx_hit = tx_cnt < st.tx_trig;
    end
    next_st.irq = rx_hit || tx_hit || shared_irq_in;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign irq           = st.irq;
  assign txd           = st.txd;
  assign driver_enable = st.drive;
  assign rs232_select  = st.sel232;
  assign half_duplex   = st.half;
  assign bus_idle      = st.bus_idle;
  // One-hot idle bit, so the output is just the inverted idle flip-flop
  assign tx_active     = !st.tx_state[0];

  // ==========================================================
  // Checks
  rx_trigger_irq_a: assert property (
    @(posedge clock) disable iff (rst)
    rx_cnt != '0 && rx_cnt >= st.rx_trig |=> irq)
    else $error("receive level reached without interrupt");

  tx_trigger_irq_a: assert property (
    @(posedge clock) disable iff (rst)
    st.tx_trig != '0 && tx_cnt < st.tx_trig |=> irq)
    else $error("transmit level low without interrupt");

  tx_zero_hold_a: assert property (
    @(posedge clock) disable iff (rst)
    st.tx_trig == '0 && st.tx_state != uart_pkg::TX_IDLE &&
    !shared_irq_in && !rx_hit |=> !irq)
    else $error("transmit interrupt before transmitter idle");

  defaults_load_a: assert property (
    @(posedge clock) disable iff (rst)
    cfg_defaults |=> st.rx_trig == RW'(`DEF_RX_TRIGGER) && rs232_select &&
    st.deferral && st.auto_dir)
    else $error("defaults not applied");

  prediv_rate_a: assert property (
    @(posedge clock) disable iff (rst)
    st.tick && st.pre_div == 8'h01 && st.baud_div == 16'h0000 &&
    !cfg_write && !cfg_defaults |=> !st.tick ##1 st.tick)
    else $error("tick spacing ignores pre-divisor");

  rs422_no_defer_a: assert property (
    @(posedge clock) disable iff (rst)
    st.mode == uart_pkg::MODE_RS422 && st.tick &&
    st.tx_state == uart_pkg::TX_DEFER |=>
    st.tx_state == uart_pkg::TX_SHIFT)
    else $error("forced RS-422 deferred a character");

  busy_bus_hold_a: assert property (
    @(posedge clock) disable iff (rst)
    defer_active && !st.bus_idle &&
    st.tx_state == uart_pkg::TX_DEFER |=>
    st.tx_state != uart_pkg::TX_SHIFT)
    else $error("sent onto a busy bus");

  driver_window_a: assert property (
    @(posedge clock) disable iff (rst)
    st.half && st.auto_dir |->
    driver_enable == (st.tx_state == uart_pkg::TX_SHIFT))
    else $error("driver on outside a character");

  half_rx_mute_a: assert property (
    @(posedge clock) disable iff (rst)
    st.mode == uart_pkg::MODE_RS485 && driver_enable &&
    st.rx_state == uart_pkg::RX_IDLE |=>
    st.rx_state == uart_pkg::RX_IDLE)
    else $error("receiver heard own half-duplex echo");

endmodule

// [design/stream_fifo.sv]
// Byte FIFO with registered output stage and registered fill ready
`timescale 1ns/10ps
module stream_fifo #(
  parameter  int WIDTH = 8,
  parameter  int DEPTH = 16,
  localparam int AW    = $clog2(DEPTH),
  localparam int CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic    clock,
  input  wire logic    rst,
  // Streams
  stream_if.sink       fill,
  stream_if.source     drain,
  // Level, output stage included
  output logic [CW-1:0] count
);

  typedef struct packed {
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    mem_cnt;
    logic [CW-1:0]    count;
    logic             room;
    logic             out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_type;

  fifo_state_type   st;
  fifo_state_type   next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             accept;
  logic             pop_mem;

  // ==========================================================
  // Control
  always_comb begin
    next_st = st;
    accept  = fill.valid && st.room;
    pop_mem = (st.mem_cnt != '0) && (!st.out_valid || drain.ready);
    if (pop_mem) begin
      next_st.out_valid = 1'b1;
      next_st.out_data  = mem[st.rd_ptr];
      next_st.rd_ptr    = (st.rd_ptr == AW'(DEPTH - 1)) ? '0
                          : st.rd_ptr + AW'(1);
    end else if (drain.ready) begin
      next_st.out_valid = 1'b0;
    end
    if (accept) begin
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0
                       : st.wr_ptr + AW'(1);
    end
    next_st.mem_cnt = st.mem_cnt + CW'(accept) - CW'(pop_mem);
    next_st.count   = next_st.mem_cnt + CW'(next_st.out_valid);
    // Ready is registered, so the limit counts the output stage too
    next_st.room    = next_st.count < CW'(DEPTH);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '{room: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clock) begin
    if (accept) begin
      mem[st.wr_ptr] <= fill.data;
    end
  end

  assign fill.ready  = st.room;
  assign drain.valid = st.out_valid;
  assign drain.data  = st.out_data;
  assign count       = st.count;

  // ==========================================================
  // Checks
  fifo_full_a: assert property (@(posedge clock) disable iff (rst)
    st.count == CW'(DEPTH) |-> !fill.ready)
    else $error("fifo accepts data while full");

  out_hold_a: assert property (@(posedge clock) disable iff (rst)
    drain.valid && !drain.ready |=> drain.valid && $stable(drain.data))
    else $error("fifo output changed while stalled");

endmodule

// [design/stream_if.sv]
// Valid/ready byte stream between the port logic and its FIFOs
`timescale 1ns/10ps
interface stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface

// [design/uart_defs.svh]
// Constants for the serial port with FIFOs and RS-485 direction control
//
// What this block does
// - The interrupt rises once the receive FIFO holds at least the receive trigger level and at least one byte.
// - The interrupt rises while the transmit FIFO level is below the transmit trigger level.
// - With a transmit trigger of zero the transmit interrupt waits until the transmitter is fully idle.
// - Defaults give a receive trigger of 112 bytes and a transmit FIFO of 128 bytes.
// - The reference clock is divided by a programmable pre-divisor before the baud generator.
// - Each port offers forced RS-232 (default), automatic RS-422/485, forced RS-422 and forced RS-485.
// - In automatic mode the port detects full or half duplex by itself and steers its lines to match.
// - Forced RS-422 keeps carrier-sense deferral off whatever its enable says.
// - Forced RS-485 is half duplex, sending and receiving on one pair.
// - With deferral on in half duplex a queued character starts only on an idle bus, unless it follows straight on from the character before.
// - While the bus carries traffic the pending character is held back; deferral is on by default.
// - With automatic direction in half duplex the line driver is on only while data is sent, else floating; full duplex drives always.
// - Automatic driver direction is on by default.
// - All interrupts of the ports leave on one shared interrupt line.
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH

// ==========================================================
// Defaults
`define DEF_RX_TRIGGER   112
`define DEF_TX_TRIGGER   0
`define DEF_TX_DEPTH     128
`define DEF_RX_DEPTH     128
`define DEF_PRE_DIV      8'h00
`define DEF_BAUD_DIV     16'h0007
`define REF_CLOCK_HZ     14745600

// ==========================================================
// Timing
`define CLOCK_PERIOD_NS  25
`define OVERSAMPLE       16
`define CHAR_BITS        10
`define DATA_BITS        8
`define MID_PHASE        4'h7
`define LAST_PHASE       4'hF
`define IDLE_TICKS       (`CHAR_BITS * `OVERSAMPLE)

`endif

// [design/uart_pkg.sv]
// Types used by the serial port for its line modes and state machines
package uart_pkg;

  typedef enum logic [1:0] {
    MODE_RS232 = 2'h0,
    MODE_AUTO  = 2'h1,
    MODE_RS422 = 2'h2,
    MODE_RS485 = 2'h3
  } mode_type;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_DEFER = 3'b010,
    TX_SHIFT = 3'b100
  } tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } rx_state_type;

endpackage

// [verification/remote_node.sv]
// Remote serial node: sends on rxd, captures what the port drives
`timescale 1ns/10ps
module remote_node #(
  // Bit time agreed with the divisors the bench programs
  parameter int BIT_CLOCKS = 16
) (
  // Clock
  input  wire logic clock,
  // Line
  input  wire logic txd,
  input  wire logic driver_enable,
  input  wire logic echo,
  output logic      rxd
);
  logic       line;
  logic       seen;
  logic [7:0] cap;
  logic [7:0] got[$];

  // ======
  // Line
  // Bias resistors pull a released bus to the idle level
  assign seen = driver_enable ? txd : 1'b1;
  assign rxd  = echo ? seen : line;
  initial line = 1'b1;

  task automatic send(input logic [7:0] b);
    line <= 1'b0;
    repeat (BIT_CLOCKS) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      line <= b[i];
      repeat (BIT_CLOCKS) @(posedge clock);
    end
    line <= 1'b1;
    repeat (BIT_CLOCKS) @(posedge clock);
  endtask

  // ======
  // Capture, sampled at bit centres
  always begin
    @(negedge seen);
    repeat (BIT_CLOCKS / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLOCKS) @(posedge clock);
      cap[i] = seen;
    end
    got.push_back(cap);
    repeat (BIT_CLOCKS) @(posedge clock);
  end
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the serial port
`timescale 1ns/10ps
`include "uart_defs.svh"
module tb_top;
  logic               clock;
  logic               rst;
  logic               cfg_write;
  logic               cfg_defaults;
  uart_pkg::mode_type cfg_mode;
  logic               cfg_carrier_sense_deferral;
  logic               cfg_auto_driver_direction;
  logic [7:0]         cfg_rx_trigger;
  logic [7:0]         cfg_tx_trigger;
  logic [7:0]         cfg_pre_divisor;
  logic [15:0]        cfg_baud_divisor;
  logic               manual_drive;
  logic [7:0]         tx_data;
  logic               tx_valid;
  logic               tx_ready;
  logic [7:0]         rx_data;
  logic               rx_valid;
  logic               rx_ready;
  logic               shared_irq_in;
  logic               irq;
  logic               rxd;
  logic               txd;
  logic               driver_enable;
  logic               rs232_select;
  logic               half_duplex;
  logic               bus_idle;
  logic               tx_active;
  logic               echo;
  int                 err_count;
  int                 samples_checked;
  int                 n;
  int                 m;
  int                 p;
  int                 q;
  logic [7:0]         sent[$];

  serial_port i_dut (.clock, .rst, .cfg_write, .cfg_defaults, .cfg_mode,
    .cfg_carrier_sense_deferral, .cfg_auto_driver_direction,
    .cfg_rx_trigger, .cfg_tx_trigger, .cfg_pre_divisor, .cfg_baud_divisor,
    .manual_drive, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
    .rx_ready, .shared_irq_in, .irq, .rxd, .txd, .driver_enable,
    .rs232_select, .half_duplex, .bus_idle, .tx_active);
  remote_node #(.BIT_CLOCKS(16)) i_node (.clock, .txd, .driver_enable,
    .echo, .rxd);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ======
  // Helpers
  function automatic int low_clocks(int pre, int bd, int bits);
    return bits * `OVERSAMPLE * (pre + 1) * (bd + 1);
  endfunction
  function automatic logic [7:0] pat(int i);
    return 8'(i * 7 + 3);
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input uart_pkg::mode_type md, input logic [7:0] rxt,
                     input logic [7:0] txt, input logic [7:0] pre,
                     input logic [15:0] bd);
    cfg_mode         <= md;
    cfg_rx_trigger   <= rxt;
    cfg_tx_trigger   <= txt;
    cfg_pre_divisor  <= pre;
    cfg_baud_divisor <= bd;
    cfg_write        <= 1'b1;
    tick(1);
    cfg_write <= 1'b0;
    tick(1);
  endtask
  task automatic put(input logic [7:0] v);
    tx_data  <= v;
    tx_valid <= 1'b1;
    do tick(1); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask
  // Caller holds rx_ready high
  task automatic get(input logic [7:0] exp);
    n = 0;
    do begin tick(1); n++; end while (rx_valid !== 1'b1 && n < 60);
    check_byte(rx_data, exp);
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ======
  // Watchdog, well beyond the expected run of about 22000 cycles
  initial begin
    tick(60000);
    err_count++;
    test_done();
  end

  // ======
  // Tests
  initial begin
    {rst, echo} = 2'b10;
    {cfg_write, cfg_defaults, manual_drive, tx_valid, rx_ready} = 5'h00;
    {cfg_carrier_sense_deferral, cfg_auto_driver_direction} = 2'b11;
    {cfg_rx_trigger, cfg_tx_trigger, cfg_pre_divisor} = 24'h000000;
    {cfg_baud_divisor, tx_data, shared_irq_in} = 25'h0000000;
    cfg_mode = uart_pkg::MODE_RS232;
    {err_count, samples_checked} = 64'h0;
    n = $urandom(12);
    tick(5);
    rst <= 1'b0;
    tick(3);
    check({irq, txd, rs232_select}, 3'b111);
    cfg_mode <= uart_pkg::MODE_RS485;
    {cfg_write, cfg_defaults} <= 2'b11;
    tick(1);
    {cfg_write, cfg_defaults} <= 2'b00;
    tick(1);
    check({rs232_select, half_duplex}, 2'b10);
    $display("test reset done");
    // Fill the transmit FIFO, then receive up to the trigger meanwhile
    cfg(uart_pkg::MODE_RS232, 8'h70, 8'h00, 8'h00, 16'h0000);
    i_node.got.delete();
    n = 0;
    tx_data  <= pat(0);
    tx_valid <= 1'b1;
    do begin
      tick(1);
      if (tx_ready === 1'b1) begin
        n++;
        tx_data <= pat(n);
      end
    end while (tx_ready === 1'b1 && n < 200);
    tx_valid <= 1'b0;
    check(n, `DEF_TX_DEPTH + 1);
    for (int i = 0; i < 112; i++) begin
      sent.push_back(8'($urandom));
      i_node.send(sent[i]);
      if (i == 110) begin
        tick(3);
        check(irq, 0);
        shared_irq_in <= 1'b1;
        tick(2);
        check(irq, 1);
        shared_irq_in <= 1'b0;
        tick(2);
      end
    end
    tick(3);
    check(irq, 1);
    rx_ready <= 1'b1;
    while (sent.size() > 0) get(sent.pop_front());
    tick(3);
    check(irq, 0);
    for (n = 0; n < 30000 && tx_active !== 1'b0; n++) tick(1);
    tick(3);
    check(irq, 1);
    check(i_node.got.size(), `DEF_TX_DEPTH + 1);
    check_byte(i_node.got[128], pat(128));
    $display("test fifo done");
    // Forced full duplex starts at once despite traffic on rxd
    cfg(uart_pkg::MODE_RS422, 8'h01, 8'h00, 8'h00, 16'h0000);
    check(half_duplex, 0);
    i_node.got.delete();
    fork
      i_node.send(8'h5A);
      begin
        tick(40);
        put(8'hC3);
        for (n = 0; n < 40 && txd !== 1'b0; n++) tick(1);
        check(n < 40, 1);
      end
    join
    get(8'h5A);
    tick(200);
    check_byte(i_node.got[0], 8'hC3);
    $display("test full duplex done");
    // Half duplex: deferral behind traffic, driver only while sending
    cfg(uart_pkg::MODE_RS485, 8'h01, 8'h00, 8'h00, 16'h0000);
    check({half_duplex, driver_enable}, 2'b10);
    tick(200);
    check(bus_idle, 1);
    i_node.got.delete();
    fork
      i_node.send(8'hA5);
      begin tick(20); put(8'h3C); end
    join
    for (n = 0; n < 400 && driver_enable !== 1'b1; n++) tick(1);
    check(n >= 128 && n <= 200, 1);
    for (m = 0; m < 400 && driver_enable === 1'b1; m++) tick(1);
    check(m >= 158 && m <= 170, 1);
    check_byte(i_node.got[0], 8'h3C);
    $display("test half duplex done");
    // Automatic mode learns half duplex from an echoing bus
    cfg(uart_pkg::MODE_AUTO, 8'h01, 8'h00, 8'h00, 16'h0000);
    check({half_duplex, driver_enable}, 2'b01);
    echo <= 1'b1;
    put(8'h96);
    tick(3);
    for (n = 0; n < 400 && tx_active !== 1'b0; n++) tick(1);
    echo <= 1'b0;
    tick(3);
    check({half_duplex, driver_enable}, 2'b10);
    $display("test auto done");
    // Manual direction on a shared pair, nonzero transmit trigger
    {cfg_auto_driver_direction, manual_drive} <= 2'b01;
    cfg(uart_pkg::MODE_RS485, 8'h70, 8'h04, 8'h00, 16'h0000);
    tick(1);
    check({driver_enable, irq}, 2'b11);
    {cfg_auto_driver_direction, manual_drive} <= 2'b10;
    $display("test manual done");
    // Pre-divisor stretches every bit
    p = $urandom_range(3, 1);
    q = $urandom_range(1, 0);
    cfg(uart_pkg::MODE_RS232, 8'h01, 8'h00, 8'(p), 16'(q));
    put(8'hF0);
    for (n = 0; n < 900 && txd !== 1'b0; n++) tick(1);
    for (n = 0; n < 900 && txd === 1'b0; n++) tick(1);
    check(n, low_clocks(p, q, 5));
    $display("test divisor done");
    test_done();
  end
endmodule
